// >>> pkg/acts_pkg.sv
// Package for the ADC channel trigger select block
`default_nettype none
package acts_pkg;
    localparam int NUM_PAIRS = 6;
    localparam int NUM_CHAN  = 24;
    localparam int CODE_W    = 5;
    localparam int ADDR_W    = 8;
    // Register byte offsets: low x at 8x, high x at 8x+4
    localparam logic [ADDR_W-1:0] OFS_LOW_0   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PAIR_STRIDE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_HIGH_ADD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LAST    = 8'h2c;
    // Field positions
    localparam int LO_FIELD_LSB = 0;
    localparam int HI_FIELD_LSB = 8;
    localparam logic [15:0] REG_RW_MASK = 16'h1f1f;
    localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;
    // Trigger codes
    localparam logic [CODE_W-1:0] CODE_NONE      = 5'h00;
    localparam logic [CODE_W-1:0] CODE_SW_COMMON = 5'h01;
    localparam logic [CODE_W-1:0] CODE_SW_LEVEL  = 5'h02;
    localparam logic [CODE_W-1:0] CODE_PWM_SEV   = 5'h04;
    localparam logic [CODE_W-1:0] CODE_PWM_PRI1  = 5'h05;
    localparam logic [CODE_W-1:0] CODE_TMR1      = 5'h0c;
    localparam logic [CODE_W-1:0] CODE_TMR2      = 5'h0d;
    localparam logic [CODE_W-1:0] CODE_PWM_SSEV  = 5'h0e;
    localparam logic [CODE_W-1:0] CODE_PWM_SEC1  = 5'h0f;
    localparam logic [CODE_W-1:0] CODE_OC1       = 5'h16;
    localparam logic [CODE_W-1:0] CODE_OC2       = 5'h17;
    localparam logic [CODE_W-1:0] CODE_PWM_CL1   = 5'h18;
    localparam logic [CODE_W-1:0] CODE_EXT_PIN   = 5'h1f;
    localparam int NUM_PWM_GEN = 5;
    // Trigger source bundle from timing peripherals, all on clk
    typedef struct packed {
        logic                   sw_common;
        logic                   sw_level;
        logic                   pwm_sev;
        logic                   pwm_ssev;
        logic [NUM_PWM_GEN-1:0] pwm_pri;
        logic [NUM_PWM_GEN-1:0] pwm_sec;
        logic [NUM_PWM_GEN-1:0] pwm_cl;
        logic                   tmr1;
        logic                   tmr2;
        logic                   oc1;
        logic                   oc2;
    } acts_src_t;
endpackage : acts_pkg
`default_nettype wire

// >>> rtl/acts_top.sv
// ADC channel trigger source selection with APB register access
`default_nettype none
module acts_top
    import acts_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Trigger sources, synchronous to clk
    input  wire acts_src_t           src,
    // External trigger pin, asynchronous
    input  wire logic                external_trigger_pin,
    // Conversion start per channel
    output logic      [NUM_CHAN-1:0] conv_start
);

    // Pin synchroniser
    logic ext_meta_q;
    logic ext_sync_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
        end
        else
        begin
            ext_meta_q <= external_trigger_pin;
            ext_sync_q <= ext_meta_q;
        end
    end

    // APB decode; zero wait states
    wire             acc      = psel && penable;
    wire             wr_en    = acc && pwrite;
    wire [ADDR_W-1:0] idx_w   = paddr >> 2;
    wire [2:0]       pair_sel = idx_w[3:1];
    wire             hi_sel   = idx_w[0];
    wire             in_range = (paddr <= OFS_LAST) && (paddr[1:0] == 2'b00);
    assign pready  = 1'b1;
    // Unmapped or misaligned addresses answer with an error
    assign pslverr = acc && !in_range;

    // Channel codes, one per channel
    logic [CODE_W-1:0] code_q [NUM_CHAN];
    logic [15:0]       reg_rd [2*NUM_PAIRS];

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++)
        begin : g_chan
            localparam int REG_IDX = g / 2;
            localparam bit UPPER   = (g % 2) == 1;
            localparam int LSB     = UPPER ? HI_FIELD_LSB : LO_FIELD_LSB;
            // Register index 2x is low, 2x+1 is high
            wire sel = in_range && wr_en && ({pair_sel, hi_sel} == 4'(REG_IDX));
            wire lane = UPPER ? pstrb[1] : pstrb[0];
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    code_q[g] <= CODE_RESET;
                else if (sel && lane)
                    code_q[g] <= pwdata[LSB +: CODE_W];
            end

            // Source mux; reserved codes fall to zero
            wire [CODE_W-1:0] c = code_q[g];
            wire [CODE_W-1:0] pri_n = c - CODE_PWM_PRI1;
            wire [CODE_W-1:0] sec_n = c - CODE_PWM_SEC1;
            wire [CODE_W-1:0] cl_n  = c - CODE_PWM_CL1;
            wire hit_pri = (c >= CODE_PWM_PRI1) && (pri_n < 5'(NUM_PWM_GEN));
            wire hit_sec = (c >= CODE_PWM_SEC1) && (sec_n < 5'(NUM_PWM_GEN));
            wire hit_cl  = (c >= CODE_PWM_CL1) && (cl_n < 5'(NUM_PWM_GEN));
            wire trig =
                  ((c == CODE_SW_COMMON) && src.sw_common)
                | ((c == CODE_SW_LEVEL)  && src.sw_level)
                | ((c == CODE_PWM_SEV)   && src.pwm_sev)
                | (hit_pri && src.pwm_pri[pri_n[2:0]])
                | ((c == CODE_TMR1)      && src.tmr1)
                | ((c == CODE_TMR2)      && src.tmr2)
                | ((c == CODE_PWM_SSEV)  && src.pwm_ssev)
                | (hit_sec && src.pwm_sec[sec_n[2:0]])
                | ((c == CODE_OC1)       && src.oc1)
                | ((c == CODE_OC2)       && src.oc2)
                | (hit_cl && src.pwm_cl[cl_n[2:0]])
                | ((c == CODE_EXT_PIN)   && ext_sync_q);
            // Registered start; code 0 matches no term above
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    conv_start[g] <= 1'b0;
                else
                    conv_start[g] <= trig;
            end
        end
        for (g = 0; g < 2*NUM_PAIRS; g++)
        begin : g_rd
            // Unimplemented bits read zero
            assign reg_rd[g] = ({3'b000, code_q[2*g+1], 3'b000, code_q[2*g]}) & REG_RW_MASK;
        end
    endgenerate

    // Read data registered during setup so it is stable in access phase
    wire [3:0]  rd_idx  = {pair_sel, hi_sel};
    wire [31:0] rd_word = (in_range && rd_idx < 4'(2*NUM_PAIRS)) ? {16'h0000, reg_rd[rd_idx]}
                                                                  : 32'h0000_0000;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_word;
    end

    // Helper for the level trigger check
    logic lvl_ch0_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lvl_ch0_q <= 1'b0;
        else
            lvl_ch0_q <= (code_q[0] == CODE_SW_LEVEL) && src.sw_level;
    end

    property p_none_no_start;
        @(posedge clk) disable iff (!arst_n)
        (code_q[0] == CODE_NONE) |=> !conv_start[0];
    endproperty
    a_none_no_start: assert property (p_none_no_start) else $error("code 0 started");

    property p_reset_codes;
        @(posedge clk) $rose(arst_n) |-> (code_q[5] == CODE_RESET) && (code_q[23] == CODE_RESET);
    endproperty
    a_reset_codes: assert property (p_reset_codes) else $error("code not cleared");

    property p_common;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[1] == CODE_SW_COMMON) && src.sw_common) |=> conv_start[1];
    endproperty
    a_common: assert property (p_common) else $error("common sw missed");

    property p_level;
        @(posedge clk) disable iff (!arst_n)
        lvl_ch0_q |-> conv_start[0];
    endproperty
    a_level: assert property (p_level) else $error("level sw missed");

    property p_pri3;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[2] == 5'h07) && src.pwm_pri[2]) |=> conv_start[2];
    endproperty
    a_pri3: assert property (p_pri3) else $error("pwm3 primary missed");

    property p_cl5;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[3] == 5'h1c) && src.pwm_cl[4]) |=> conv_start[3];
    endproperty
    a_cl5: assert property (p_cl5) else $error("pwm5 limit missed");

    property p_ext;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[4] == CODE_EXT_PIN) && ext_sync_q) |=> conv_start[4];
    endproperty
    a_ext: assert property (p_ext) else $error("ext pin missed");

    property p_write_low;
        @(posedge clk) disable iff (!arst_n)
        (wr_en && paddr == OFS_LOW_0 && pstrb == 4'hf) |=>
            (code_q[0] == $past(pwdata[4:0])) && (code_q[1] == $past(pwdata[12:8]));
    endproperty
    a_write_low: assert property (p_write_low) else $error("low write wrong");

    property p_rsvd_zero;
        @(posedge clk) disable iff (!arst_n)
        (psel && !penable && !pwrite) |=> (prdata[15:13] == 3'b000) && (prdata[7:5] == 3'b000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

    // One channel per remaining source; bench rotation reaches each code on it
    property p_sev;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[5] == CODE_PWM_SEV) && src.pwm_sev) |=> conv_start[5];
    endproperty
    a_sev: assert property (p_sev) else $error("pwm special event missed");

    property p_pri1;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[6] == CODE_PWM_PRI1) && src.pwm_pri[0]) |=> conv_start[6];
    endproperty
    a_pri1: assert property (p_pri1) else $error("pwm1 primary missed");

    property p_tmr1;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[7] == CODE_TMR1) && src.tmr1) |=> conv_start[7];
    endproperty
    a_tmr1: assert property (p_tmr1) else $error("timer1 match missed");

    property p_tmr2;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[8] == CODE_TMR2) && src.tmr2) |=> conv_start[8];
    endproperty
    a_tmr2: assert property (p_tmr2) else $error("timer2 match missed");

    property p_ssev;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[9] == CODE_PWM_SSEV) && src.pwm_ssev) |=> conv_start[9];
    endproperty
    a_ssev: assert property (p_ssev) else $error("pwm secondary event missed");

    property p_sec1;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[10] == CODE_PWM_SEC1) && src.pwm_sec[0]) |=> conv_start[10];
    endproperty
    a_sec1: assert property (p_sec1) else $error("pwm1 secondary missed");

    property p_oc1;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[11] == CODE_OC1) && src.oc1) |=> conv_start[11];
    endproperty
    a_oc1: assert property (p_oc1) else $error("compare 1 missed");

    property p_oc2;
        @(posedge clk) disable iff (!arst_n)
        ((code_q[12] == CODE_OC2) && src.oc2) |=> conv_start[12];
    endproperty
    a_oc2: assert property (p_oc2) else $error("compare 2 missed");

    // Reserved code must stay quiet even with every source high
    property p_rsvd_quiet;
        @(posedge clk) disable iff (!arst_n)
        (code_q[13] == 5'h03) |=> !conv_start[13];
    endproperty
    a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("reserved code started");

    // Pin path takes two sync stages, then the start register
    sequence s_ext_armed;
        (code_q[4] == CODE_EXT_PIN) && ext_meta_q;
    endsequence

    sequence s_ext_held;
        code_q[4] == CODE_EXT_PIN;
    endsequence

    property p_ext_path;
        @(posedge clk) disable iff (!arst_n)
        s_ext_armed ##1 s_ext_held |=> conv_start[4];
    endproperty
    a_ext_path: assert property (p_ext_path) else $error("pin path missed");

    property p_write_high;
        @(posedge clk) disable iff (!arst_n)
        (wr_en && paddr == OFS_HIGH_ADD && pstrb[1]) |=>
            (code_q[3] == $past(pwdata[12:8]));
    endproperty
    a_write_high: assert property (p_write_high) else $error("high write wrong");

    // Lane strobe guards the upper field
    property p_lane_keep;
        @(posedge clk) disable iff (!arst_n)
        (wr_en && paddr == OFS_LOW_0 && pstrb == 4'h1) |=> (code_q[1] == $past(code_q[1]));
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("masked lane written");

    property p_err_no_write;
        @(posedge clk) disable iff (!arst_n)
        (wr_en && !in_range) |=> (code_q[0] == $past(code_q[0]));
    endproperty
    a_err_no_write: assert property (p_err_no_write) else $error("bad address wrote");

    property p_slverr;
        @(posedge clk) disable iff (!arst_n)
        (acc && paddr > OFS_LAST) |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("no error on unmapped");

    property p_ready;
        @(posedge clk) disable iff (!arst_n)
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access stalled");

    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence

    property p_rd_range;
        @(posedge clk) disable iff (!arst_n)
        (s_rd_setup and !in_range) |=> (prdata == 32'h0000_0000);
    endproperty
    a_rd_range: assert property (p_rd_range) else $error("unmapped read not zero");

    property p_hi_zero;
        @(posedge clk) disable iff (!arst_n)
        s_rd_setup |=> (prdata[31:16] == 16'h0000);
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper half not zero");

    property p_read_code;
        @(posedge clk) disable iff (!arst_n)
        (s_rd_setup and paddr == OFS_LOW_0) |=> (prdata[4:0] == $past(code_q[0]));
    endproperty
    a_read_code: assert property (p_read_code) else $error("read code wrong");

    // Starts must be clear as reset lets go
    property p_reset_starts;
        @(posedge clk) $rose(arst_n) |-> (conv_start == '0);
    endproperty
    a_reset_starts: assert property (p_reset_starts) else $error("start not cleared");

endmodule // acts_top
`default_nettype wire

// >>> tb/acts_src_model.sv
// Trigger source model standing in for the timing peripherals
`default_nettype none
module acts_src_model
    import acts_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Pattern requested by the bench
    input  wire logic [23:0] pat,
    // Trigger levels towards the selector
    output acts_src_t        src,
    output logic             pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Levels move only after an edge, as the real peripherals do
    always @(posedge clk)
    begin
        src <= pat[22:0];
        pin <= pat[23];
    end
endmodule // acts_src_model
`default_nettype wire

// >>> tb/acts_top_tb.sv
// Self-checking bench for the channel trigger selector
`default_nettype none
module acts_top_tb
    import acts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                clk, arst_n, psel, penable, pwrite, pready, pslverr, pin;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata, prdata, q, d;
    logic [3:0]          pstrb;
    logic [23:0]         pat;
    logic [NUM_CHAN-1:0] conv_start;
    logic                e;
    acts_src_t           src;
    logic [15:0]         mdl [12];
    logic [4:0]          vq [$];
    int                  n_fail, n_tests, seed;

    acts_src_model src_model (.clk(clk), .pat(pat), .src(src), .pin(pin));
    acts_top uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
        .external_trigger_pin(pin), .conv_start(conv_start));

    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        int i;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        pstrb  <= s;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        if (i == 16)
        begin
            n_fail++;
            print_verdict();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int r, input logic [31:0] wd, input logic [3:0] s);
        apb(1'b1, 8'(r * 4), wd, s, q, e);
        chk(32'(e), 32'h0);
        if (s[0])
            mdl[r][7:0] = wd[7:0] & 8'h1f;
        if (s[1])
            mdl[r][15:8] = wd[15:8] & 8'h1f;
    endtask

    task automatic rdc(input int r);
        apb(1'b0, 8'(r * 4), 32'h0, 4'hf, q, e);
        chk(q, {16'h0, mdl[r]});
    endtask

    function automatic logic [NUM_CHAN-1:0] exp_start(input logic [23:0] p);
        logic [NUM_CHAN-1:0] v;
        acts_src_t           s;
        logic [4:0]          c;
        s = p[22:0];
        for (int ch = 0; ch < NUM_CHAN; ch++)
        begin
            c = ch[0] ? mdl[ch / 2][12:8] : mdl[ch / 2][4:0];
            case (c) inside
                5'h01: v[ch] = s.sw_common;
                5'h02: v[ch] = s.sw_level;
                5'h04: v[ch] = s.pwm_sev;
                [5'h05:5'h09]: v[ch] = s.pwm_pri[c - 5'h05];
                5'h0c: v[ch] = s.tmr1;
                5'h0d: v[ch] = s.tmr2;
                5'h0e: v[ch] = s.pwm_ssev;
                [5'h0f:5'h13]: v[ch] = s.pwm_sec[c - 5'h0f];
                5'h16: v[ch] = s.oc1;
                5'h17: v[ch] = s.oc2;
                [5'h18:5'h1c]: v[ch] = s.pwm_cl[c - 5'h18];
                5'h1f: v[ch] = p[23];
                default: v[ch] = 1'b0;
            endcase
        end
        return v;
    endfunction

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        seed = 59276;
        {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb, pat} = '0;
        mdl = '{default: '0};
        for (int c = 0; c < 32; c++)
            if (!(c inside {3, 10, 11, 20, 21, 29, 30}))
                vq.push_back(5'(c));
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (int r = 0; r < 12; r++)
            rdc(r);
        apb(1'b1, 8'h30, 32'hffff, 4'hf, q, e);
        chk(32'(e), 32'h1);
        apb(1'b0, 8'h02, 32'h0, 4'hf, q, e);
        chk({q[31:1], e}, 32'h1);
        wr(0, 32'hffff, 4'h1);
        rdc(0);
        // Every channel walks through every legal code over the rounds
        for (int rnd = 0; rnd < 25; rnd++)
        begin
            for (int r = 0; r < 12; r++)
            begin
                d = $random(seed);
                d[12:8] = vq[(rnd + 2 * r + 1) % 25];
                d[4:0] = vq[(rnd + 2 * r) % 25];
                wr(r, d, 4'hf);
                rdc(r);
            end
            repeat (4)
            begin
                pat <= 24'($random(seed));
                repeat (5) @(posedge clk);
                @(negedge clk);
                chk(32'(conv_start), 32'(exp_start(pat)));
                @(posedge clk);
            end
        end
        arst_n <= 1'b0;
        mdl = '{default: '0};
        @(negedge clk);
        chk(32'(conv_start), 32'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        for (int r = 0; r < 12; r++)
            rdc(r);
        print_verdict();
    end
endmodule // acts_top_tb
`default_nettype wire
